// ### verilog/prm_defs.svh
// Purpose: Constants of the pin remap matrix
// Assumes: Included by the package only; design modules use its macros through the package
// Notes:   Definitions only
`ifndef PRM_DEFS_SVH
`define PRM_DEFS_SVH

// ------------------------------------------------------------
// Field layout
// ------------------------------------------------------------
`define PRM_FIELD_W      6
`define PRM_LO_FIELD_LSB 0
`define PRM_HI_FIELD_LSB 8
`define PRM_LOCK_BIT     6

// ------------------------------------------------------------
// Reset values and special codes
// ------------------------------------------------------------
`define PRM_SEL_NONE     6'h3F
`define PRM_FN_NULL      6'h00
`define PRM_LOCK_RESET   1'h0

// ------------------------------------------------------------
// Unlock keys, written to the low byte of the oscillator control register
// ------------------------------------------------------------
`define PRM_KEY_FIRST    8'h46
`define PRM_KEY_SECOND   8'h57

`endif

// ### verilog/prm_pkg.sv
// Purpose: Types of the pin remap matrix
// Assumes: prm_defs.svh holds the numbers
// Notes:   Function codes follow enum order, null first
package prm_pkg;
`include "prm_defs.svh"

   typedef logic [`PRM_FIELD_W-1:0] prm_field_t;

   // ------------------------------------------------------------
   // Output function codes, 0 to 27
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      fn_null, fn_cmp_one, fn_cmp_two,
      fn_ser1_tx, fn_ser1_rts, fn_ser2_tx, fn_ser2_rts,
      fn_spi1_dout, fn_spi1_clk, fn_spi1_sel,
      fn_spi2_dout, fn_spi2_clk, fn_spi2_sel,
      fn_ocmp1, fn_ocmp2, fn_ocmp3, fn_ocmp4, fn_ocmp5, fn_ocmp6,
      fn_ser3_tx, fn_ser3_rts, fn_ser4_tx, fn_ser4_rts,
      fn_spi3_dout, fn_spi3_clk, fn_spi3_sel,
      fn_cmp_three, fn_modulator
   } prm_fn_t;

   typedef logic [27:0] prm_fout_t;

   // Unlock sequence states
   typedef enum logic [1:0] {key_idle, key_first_seen, key_second_seen} prm_key_t;

   // Register write request
   typedef struct packed {
      logic        in_wr;
      logic        out_wr;
      logic        osc_wr;
      logic [4:0]  idx;
      logic [15:0] data;
   } prm_wr_t;

   // Register read request
   typedef struct packed {
      logic       rd_out;
      logic       rd_osc;
      logic [4:0] idx;
   } prm_rd_t;
endpackage

// ### verilog/prm_out_sel.sv
// Purpose: Picks the peripheral output named by one pin's function code
// Assumes: Codes above the last function act like null
// Notes:   Pure combinational, registered by the caller
`timescale 1ns/1ps
module prm_out_sel
   import prm_pkg::*;
(
   input  wire prm_field_t fn_code,
   input  wire prm_fout_t  periph_out,
   output logic            sel_val,
   output logic            sel_act
);
   always_comb begin
      sel_val = 1'b0;
      sel_act = 1'b0;
      if (fn_code != `PRM_FN_NULL && fn_code <= prm_field_t'(fn_modulator)) begin
         sel_val = periph_out[fn_code[4:0]];
         sel_act = 1'b1;
      end
   end
endmodule // prm_out_sel

// ### verilog/prm_shadow_mon.sv
// Purpose: Shadow copy of the mapping registers with continuous compare
// Assumes: map_d is the value the live copy loads every edge
// Notes:   A disturbed live bit shows as a mismatch one edge later
`timescale 1ns/1ps
module prm_shadow_mon
   import prm_pkg::*;
#(
   parameter int          W         = 8,
   parameter logic [W-1:0] RESET_VAL = '0
)(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] map_d,
   input  wire logic [W-1:0] map_q,
   output logic              mismatch_q
);
   typedef struct packed {
      logic [W-1:0] shadow;
      logic         mismatch;
   } sh_t;

   sh_t s_q;
   sh_t s_d;

   always_comb begin
      s_d          = s_q;
      s_d.shadow   = map_d;
      s_d.mismatch = (map_q != s_q.shadow);
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_q.shadow   <= RESET_VAL;
         s_q.mismatch <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign mismatch_q = s_q.mismatch;
endmodule // prm_shadow_mon

// ### verilog/prm_matrix.sv
// Purpose: Pin remap matrix: input select, output select, lock and monitor
// Assumes: All inputs synchronous to clk; one write strobe at a time
// Notes:   Summary of operation below, then the logic
//
// Summary of operation
// - Each peripheral input has a 6-bit pin select, two per input map register.
// - Each output pin has a 6-bit function code, two per output map register.
// - Codes 1 to 27 pick comparator, serial, SPI, compare, modulator outputs.
// - Code zero leaves the pin free of any remapped output.
// - Reset loads the null code into every output function field.
// - One pin may feed many inputs; one output may drive many pins.
// - Contention is impossible by structure; no other mapping lockout exists.
// - Selecting an unimplemented pin leaves the peripheral input unmapped.
// - Output fields of unimplemented pins do not exist; writes do nothing.
// - While locked, map writes complete but leave the contents unchanged.
// - Lock bit is bit 6 of the oscillator control register.
// - Lock changes only after keys 46h then 57h to the low byte.
// - Lock holds its value until deliberately changed.
// - Shadow copies are compared always; divergence raises mismatch reset.
// - With one-way set, a set lock clears only by device reset.
// - One-way bit unprogrammed reads set: one write session only.
// - Up to 24 remappable pins, one input only; pins 4 and 12 absent.
// - Input and output mapping are independent of each other.
// - Reset loads all ones to input selects, zero to output codes.
// - Lock comes out of reset unlocked.
// - An analog pin feeds no remapped peripheral input.
// - Dedicated outputs beat remapped outputs, which beat port and parallel port.
`timescale 1ns/1ps
module prm_matrix
   import prm_pkg::*;
#(
   parameter int                NUM_IN       = 35,
   parameter int                NUM_RP       = 26,
   parameter logic [NUM_RP-1:0] IN_IMPL_MASK  = 26'h3FFEFEF,
   parameter logic [NUM_RP-1:0] OUT_IMPL_MASK = 26'h1FFEFEF
)(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire prm_wr_t           wr,
   input  wire prm_rd_t           rd,
   input  wire logic              one_way_lock_config_bit,
   input  wire logic [NUM_RP-1:0] pin_in,
   input  wire logic [NUM_RP-1:0] pin_analog,
   input  wire prm_fout_t         periph_out,
   input  wire logic [NUM_RP-1:0] fixed_oe,
   input  wire logic [NUM_RP-1:0] fixed_out,
   input  wire logic [NUM_RP-1:0] port_oe,
   input  wire logic [NUM_RP-1:0] port_out,
   output logic [NUM_IN-1:0]      periph_in,
   output logic [NUM_RP-1:0]      pin_out,
   output logic [NUM_RP-1:0]      pin_oe,
   output logic                   mapping_lock_bit,
   output logic [15:0]            rd_data,
   output logic                   config_mismatch_reset
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   localparam int MAP_W = (NUM_IN + NUM_RP) * `PRM_FIELD_W;

   typedef struct packed {
      logic [NUM_IN-1:0][5:0] in_sel;
      logic [NUM_RP-1:0][5:0] out_fn;
      logic                   lock;
      prm_key_t               key;
      logic [NUM_IN-1:0]      periph_in;
      logic [NUM_RP-1:0]      pin_out;
      logic [NUM_RP-1:0]      pin_oe;
      logic [15:0]            rd_data;
   } st_t;

   st_t               st_q;
   st_t               st_d;
   logic [NUM_RP-1:0] rm_val;
   logic [NUM_RP-1:0] rm_act;
   logic              mism;

   localparam logic [MAP_W-1:0] MAP_RESET = {{NUM_IN{`PRM_SEL_NONE}}, {NUM_RP{`PRM_FN_NULL}}};

   // ------------------------------------------------------------
   // Output function decode per pin
   // ------------------------------------------------------------
   // One mux per pin, so one function may land on many pins
   for (genvar p = 0; p < NUM_RP; p++) begin : g_pin
      prm_out_sel u_sel (
         .fn_code    (st_q.out_fn[p]),
         .periph_out (periph_out),
         .sel_val    (rm_val[p]),
         .sel_act    (rm_act[p])
      );
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [5:0] lo_idx;
      logic [5:0] hi_idx;
      logic [7:0] osc_lo;
      logic       new_lock;
      st_d     = st_q;
      lo_idx   = {wr.idx, 1'b0};
      hi_idx   = {wr.idx, 1'b1};
      osc_lo   = wr.data[7:0];
      new_lock = wr.data[`PRM_LOCK_BIT];

      // Map writes, dropped silently while locked
      if (wr.in_wr && !st_q.lock) begin
         for (int i = 0; i < NUM_IN; i++) begin
            if (6'(i) == lo_idx) begin
               st_d.in_sel[i] = wr.data[`PRM_LO_FIELD_LSB +: `PRM_FIELD_W];
            end
            if (6'(i) == hi_idx) begin
               st_d.in_sel[i] = wr.data[`PRM_HI_FIELD_LSB +: `PRM_FIELD_W];
            end
         end
      end
      if (wr.out_wr && !st_q.lock) begin
         for (int p = 0; p < NUM_RP; p++) begin
            // Fields of absent pins are not stored
            if (6'(p) == lo_idx && OUT_IMPL_MASK[p]) begin
               st_d.out_fn[p] = wr.data[`PRM_LO_FIELD_LSB +: `PRM_FIELD_W];
            end
            if (6'(p) == hi_idx && OUT_IMPL_MASK[p]) begin
               st_d.out_fn[p] = wr.data[`PRM_HI_FIELD_LSB +: `PRM_FIELD_W];
            end
         end
      end

      // Unlock sequence; any other write in between starts over
      case (st_q.key)
         key_idle: begin
            if (wr.osc_wr && osc_lo == `PRM_KEY_FIRST) begin
               st_d.key = key_first_seen;
            end
         end
         key_first_seen: begin
            if (wr.osc_wr && osc_lo == `PRM_KEY_SECOND) begin
               st_d.key = key_second_seen;
            end else if (wr.osc_wr && osc_lo == `PRM_KEY_FIRST) begin
               st_d.key = key_first_seen;
            end else if (wr.osc_wr || wr.in_wr || wr.out_wr) begin
               st_d.key = key_idle;
            end
         end
         key_second_seen: begin
            // Any osc write here ends the sequence, so a stale unlock cannot linger
            if (wr.osc_wr) begin
               // One-way option keeps a set lock until reset
               if (!(one_way_lock_config_bit && st_q.lock && !new_lock)) begin
                  st_d.lock = new_lock;
               end
               st_d.key = key_idle;
            end else if (wr.in_wr || wr.out_wr) begin
               st_d.key = key_idle;
            end
         end
         default: begin
            st_d.key = key_idle;
         end
      endcase
      // Otherwise the lock simply holds

      // Input routing; independent of the output side
      for (int i = 0; i < NUM_IN; i++) begin
         // Low unless a valid pin is found, so all ones and absent pins read 0
         st_d.periph_in[i] = 1'b0;
         for (int p = 0; p < NUM_RP; p++) begin
            // One select per input, so two pins can never contend
            if (st_q.in_sel[i] == 6'(p) && IN_IMPL_MASK[p] && !pin_analog[p]) begin
               st_d.periph_in[i] = pin_in[p];
            end
         end
      end

      // Pin drive priority: dedicated, then remapped, then port
      for (int p = 0; p < NUM_RP; p++) begin
         if (fixed_oe[p]) begin
            st_d.pin_out[p] = fixed_out[p];
            st_d.pin_oe[p]  = 1'b1;
         end else if (rm_act[p] && OUT_IMPL_MASK[p]) begin
            st_d.pin_out[p] = rm_val[p];
            st_d.pin_oe[p]  = 1'b1;
         end else begin
            st_d.pin_out[p] = port_out[p];
            st_d.pin_oe[p]  = port_oe[p];
         end
      end

      // Readback: low field in bits 5:0, high field in bits 13:8
      st_d.rd_data = 16'h0000;
      for (int i = 0; i < NUM_IN; i++) begin
         if (!rd.rd_out && !rd.rd_osc && 6'(i) == {rd.idx, 1'b0}) begin
            st_d.rd_data[5:0] = st_q.in_sel[i];
         end
         if (!rd.rd_out && !rd.rd_osc && 6'(i) == {rd.idx, 1'b1}) begin
            st_d.rd_data[13:8] = st_q.in_sel[i];
         end
      end
      for (int p = 0; p < NUM_RP; p++) begin
         if (rd.rd_out && !rd.rd_osc && 6'(p) == {rd.idx, 1'b0}) begin
            st_d.rd_data[5:0] = st_q.out_fn[p];
         end
         if (rd.rd_out && !rd.rd_osc && 6'(p) == {rd.idx, 1'b1}) begin
            st_d.rd_data[13:8] = st_q.out_fn[p];
         end
      end
      if (rd.rd_osc) begin
         st_d.rd_data[`PRM_LOCK_BIT] = st_q.lock;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_q.in_sel    <= {NUM_IN{`PRM_SEL_NONE}};
         st_q.out_fn    <= {NUM_RP{`PRM_FN_NULL}};
         st_q.lock      <= `PRM_LOCK_RESET;
         st_q.key       <= key_idle;
         st_q.periph_in <= '0;
         st_q.pin_out   <= '0;
         st_q.pin_oe    <= '0;
         st_q.rd_data   <= 16'h0000;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // Shadow monitor
   // ------------------------------------------------------------
   // Shadow loads the same next value, so only a disturbed cell differs
   prm_shadow_mon #(
      .W         (MAP_W),
      .RESET_VAL (MAP_RESET)
   ) u_shadow (
      .clk        (clk),
      .reset_n    (reset_n),
      .map_d      ({st_d.in_sel, st_d.out_fn}),
      .map_q      ({st_q.in_sel, st_q.out_fn}),
      .mismatch_q (mism)
   );

   assign periph_in             = st_q.periph_in;
   assign pin_out               = st_q.pin_out;
   assign pin_oe                = st_q.pin_oe;
   assign mapping_lock_bit      = st_q.lock;
   assign rd_data               = st_q.rd_data;
   assign config_mismatch_reset = mism;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_reset_defaults: assert property (@(posedge clk)
      !reset_n |=> (st_q.lock == 1'b0 && st_q.out_fn == '0 && (&st_q.in_sel)))
      else $error("mapping defaults wrong after reset");

   a_locked_in_hold: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q.lock && wr.in_wr && !wr.osc_wr) |=> $stable(st_q.in_sel))
      else $error("input map changed while locked");

   a_locked_out_hold: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q.lock && wr.out_wr) |=> $stable(st_q.out_fn))
      else $error("output map changed while locked");

   a_unlocked_in_wr: assert property (@(posedge clk) disable iff (!reset_n)
      (!st_q.lock && wr.in_wr && wr.idx == 5'h00)
      |=> st_q.in_sel[0] == $past(wr.data[5:0]) && st_q.in_sel[1] == $past(wr.data[13:8]))
      else $error("input map write lost");

   a_lock_bit_six: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q.key == key_second_seen && wr.osc_wr && !one_way_lock_config_bit)
      |=> st_q.lock == $past(wr.data[6]))
      else $error("lock did not follow bit 6");

   a_one_way_hold: assert property (@(posedge clk) disable iff (!reset_n)
      (one_way_lock_config_bit && st_q.lock) |=> st_q.lock)
      else $error("one-way lock was cleared");

   a_lock_needs_keys: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q.key != key_second_seen) |=> $stable(st_q.lock))
      else $error("lock changed without key sequence");

   a_seq_abort: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q.key == key_first_seen && !wr.osc_wr && (wr.in_wr || wr.out_wr))
      |=> st_q.key == key_idle ##1 (st_q.key != key_second_seen))
      else $error("key sequence not aborted");

   a_invalid_low: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q.in_sel[0] == `PRM_SEL_NONE) |=> !st_q.periph_in[0])
      else $error("unmapped input not low");

   a_fixed_first: assert property (@(posedge clk) disable iff (!reset_n)
      fixed_oe[0] |=> pin_oe[0] && pin_out[0] == $past(fixed_out[0]))
      else $error("dedicated output lost priority");

   // ------------------------------------------------------------
   // Assertions on routing and storage details
   // ------------------------------------------------------------
   // Spot checks on one or two pins or fields each, or on a whole map; random stimulus covers the rest

   a_null_port_drive: assert property (@(posedge clk) disable iff (!reset_n)
      (!fixed_oe[2] && st_q.out_fn[2] == `PRM_FN_NULL)
      |=> pin_oe[2] == $past(port_oe[2]) && pin_out[2] == $past(port_out[2]))
      else $error("null code did not fall back to port");

   a_remap_drive: assert property (@(posedge clk) disable iff (!reset_n)
      (!fixed_oe[1] && st_q.out_fn[1] == 6'h0D)
      |=> pin_oe[1] && pin_out[1] == $past(periph_out[13]))
      else $error("remapped output not on pin");

   a_shared_input: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q.in_sel[0] == 6'h03 && st_q.in_sel[1] == 6'h03 && !pin_analog[3])
      |=> periph_in[0] == $past(pin_in[3]) && periph_in[1] == $past(pin_in[3]))
      else $error("one pin did not feed two inputs");

   a_analog_in_low: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q.in_sel[2] < 6'(NUM_RP) && pin_analog[st_q.in_sel[2][4:0]])
      |=> !periph_in[2])
      else $error("analog pin fed a remapped input");

   a_absent_out_null: assert property (@(posedge clk) disable iff (!reset_n)
      (OUT_IMPL_MASK[4] || st_q.out_fn[4] == `PRM_FN_NULL)
      && (OUT_IMPL_MASK[12] || st_q.out_fn[12] == `PRM_FN_NULL))
      else $error("absent pin stored a function code");

   a_key_restart: assert property (@(posedge clk) disable iff (!reset_n)
      (st_q.key == key_first_seen && wr.osc_wr && wr.data[7:0] == `PRM_KEY_FIRST)
      |=> st_q.key == key_first_seen)
      else $error("repeated first key lost the sequence");

   a_mismatch_quiet: assert property (@(posedge clk) disable iff (!reset_n)
      !mism)
      else $error("shadow compare fired under legal writes");

   a_in_map_apart: assert property (@(posedge clk) disable iff (!reset_n)
      (wr.out_wr && !wr.in_wr) |=> $stable(st_q.in_sel))
      else $error("output map write touched input map");
endmodule // prm_matrix

// ### test/prm_far_model.sv
// Purpose: Far side of the remap matrix: peripherals and pin pads
// Assumes: seed changes only at the falling clock edge
// Notes:   Masks keep analog and dedicated drive sparse
`timescale 1ns/1ps
module prm_far_model
   import prm_pkg::*;
(
   input  wire logic [31:0] seed,
   output logic [25:0]      pin_in,
   output logic [25:0]      pin_analog,
   output prm_fout_t        periph_out,
   output logic [25:0]      fixed_oe,
   output logic [25:0]      fixed_out,
   output logic [25:0]      port_oe,
   output logic [25:0]      port_out
);
   logic [31:0] rot;
   assign rot        = {seed[15:0], seed[31:16]};
   assign pin_in     = seed[25:0];
   // Three-way and keeps analog pins rare, so most inputs stay digital
   assign pin_analog = seed[25:0] & rot[25:0] & seed[31:6];
   assign periph_out = rot[27:0];
   assign fixed_oe   = seed[30:5] & rot[25:0];
   assign fixed_out  = rot[31:6];
   assign port_oe    = seed[31:6] ^ rot[25:0];
   assign port_out   = seed[28:3];
endmodule // prm_far_model

// ### test/prm_matrix_tb.sv
// Purpose: Self-checking bench of the pin remap matrix
// Assumes: Default masks: pins 4, 12 absent, pin 25 input only
// Notes:   Shadow copies in the bench predict every read and route
`timescale 1ns/1ps
module prm_matrix_tb
   import prm_pkg::*;
;
   logic clk, reset_n, one_way_lock_config_bit, mapping_lock_bit, config_mismatch_reset;
   prm_wr_t wr;
   prm_rd_t rd;
   prm_fout_t periph_out;
   logic [25:0] pin_in, pin_analog, fixed_oe, fixed_out, port_oe, port_out, pin_out, pin_oe;
   logic [34:0] periph_in;
   logic [15:0] rd_data;
   logic [31:0] rnd;
   logic [5:0] isel [35];
   logic [5:0] ocode [26];
   logic lk;
   int key, errors, n_tests;

   prm_far_model prm_far_model_inst (.seed(rnd), .pin_in(pin_in), .pin_analog(pin_analog),
      .periph_out(periph_out), .fixed_oe(fixed_oe), .fixed_out(fixed_out),
      .port_oe(port_oe), .port_out(port_out));

   prm_matrix prm_matrix_inst (.clk(clk), .reset_n(reset_n), .wr(wr), .rd(rd),
      .one_way_lock_config_bit(one_way_lock_config_bit), .pin_in(pin_in),
      .pin_analog(pin_analog), .periph_out(periph_out), .fixed_oe(fixed_oe),
      .fixed_out(fixed_out), .port_oe(port_oe), .port_out(port_out),
      .periph_in(periph_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .mapping_lock_bit(mapping_lock_bit), .rd_data(rd_data),
      .config_mismatch_reset(config_mismatch_reset));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic void nxt();
      logic [31:0] v;
      v = rnd ^ (rnd << 13);
      v = v ^ (v >> 17);
      rnd = v ^ (v << 5);
   endfunction

   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t read got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic reset_shadow();
      foreach (isel[k]) isel[k] = 6'h3F;
      foreach (ocode[p]) ocode[p] = 6'h00;
      lk = 1'b0;
      key = 0;
   endtask

   // Strobe for one cycle, idle one, then predict what the store should hold
   task automatic wr_reg(input int kind, input int idx, input logic [15:0] data);
      int f;
      prm_wr_t w;
      w = '0;
      w.idx = idx[4:0];
      w.data = data;
      w.in_wr = (kind == 0);
      w.out_wr = (kind == 1);
      w.osc_wr = (kind == 2);
      wr = w;
      @(negedge clk);
      wr = '0;
      @(negedge clk);
      if (kind == 2) begin
         if (key == 2) lk = data[6] | (lk & one_way_lock_config_bit);
         if (key == 2) key = 0;
         else if (data[7:0] == 8'h46) key = 1;
         else if (key == 1 && data[7:0] == 8'h57) key = 2;
         else key = 0;
      end else begin
         key = 0;
         for (int k = 0; k < 2; k++) begin
            f = 2 * idx + k;
            if (!lk && kind == 0 && f < 35) isel[f] = data[8*k +: 6];
            if (!lk && kind == 1 && f < 25 && f != 4 && f != 12) ocode[f] = data[8*k +: 6];
         end
      end
   endtask

   task automatic unlock(input logic [15:0] last);
      wr_reg(2, 0, 16'h0046);
      wr_reg(2, 0, 16'h0057);
      wr_reg(2, 0, last);
   endtask

   // Input map registers 0 to 17, then output map registers 0 to 12
   task automatic chk_regs();
      logic [15:0] e;
      prm_rd_t r;
      int j;
      for (int i = 0; i < 31; i++) begin
         j = (i > 17) ? 2 * (i - 18) : 2 * i;
         r = '0;
         r.rd_out = (i > 17);
         r.idx = 5'(j / 2);
         rd = r;
         @(negedge clk);
         if (i > 17) e = {2'h0, ocode[j+1], 2'h0, ocode[j]};
         else e = {2'h0, (j < 34) ? isel[j+1] : 6'h00, 2'h0, isel[j]};
         chk_word(rd_data, e);
      end
      r = '0;
      r.rd_osc = 1'b1;
      rd = r;
      @(negedge clk);
      chk_word(rd_data, {9'h000, lk, 6'h00});
      chk_bit(mapping_lock_bit, lk, "lock");
   endtask

   function automatic logic exp_in(input logic [5:0] s);
      if (s > 25 || s == 4 || s == 12) return 1'b0;
      if (pin_analog[s]) return 1'b0;
      return pin_in[s];
   endfunction

   function automatic logic [1:0] exp_pin(input int p);
      int c;
      c = ocode[p];
      if (fixed_oe[p]) return {1'b1, fixed_out[p]};
      if (c >= 1 && c <= 27) return {1'b1, periph_out[c]};
      return {port_oe[p], port_out[p]};
   endfunction

   task automatic chk_routes();
      logic [1:0] e;
      repeat (3) @(negedge clk);
      for (int k = 0; k < 35; k++) begin
         chk_bit(periph_in[k], exp_in(isel[k]), "input");
      end
      for (int p = 0; p < 26; p++) begin
         e = exp_pin(p);
         chk_bit(pin_oe[p], e[1], "oe");
         chk_bit(pin_out[p], e[0], "out");
      end
      chk_bit(config_mismatch_reset, 1'b0, "mismatch");
   endtask

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Whole run needs about 900 cycles; the margin covers a stuck wait
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      end_sim();
   end

   initial begin
      errors = 0;
      n_tests = 0;
      rnd = 32'h0000000C;
      reset_n = 1'b0;
      one_way_lock_config_bit = 1'b1;
      wr = '0;
      rd = '0;
      reset_shadow();
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      chk_regs();
      chk_routes();
      for (int r = 0; r < 4; r++) begin
         for (int i = 0; i < 18; i++) begin
            nxt();
            wr_reg(0, i, rnd[15:0] & (r[0] ? 16'h1F1F : 16'h3F3F));
         end
         for (int i = 0; i < 13; i++) begin
            nxt();
            wr_reg(1, i, rnd[31:16] & 16'h1F1F);
         end
         chk_regs();
         chk_routes();
      end
      wr_reg(0, 0, 16'h0303);
      wr_reg(0, 1, 16'h0303);
      wr_reg(1, 0, 16'h0D0D);
      chk_routes();
      for (int c = 0; c < 28; c++) begin
         wr_reg(1, 3, {2'h0, 6'(c), 2'h0, 6'(c)});
         chk_routes();
      end
      one_way_lock_config_bit = 1'b0;
      unlock(16'h0040);
      nxt();
      wr_reg(0, 0, rnd[15:0]);
      wr_reg(1, 0, rnd[31:16]);
      chk_regs();
      chk_routes();
      wr_reg(2, 0, 16'h0046);
      wr_reg(0, 2, 16'h0000);
      wr_reg(2, 0, 16'h0057);
      wr_reg(2, 0, 16'h0000);
      chk_regs();
      wr_reg(2, 0, 16'h0046);
      wr_reg(2, 0, 16'h0046);
      unlock(16'h0000);
      for (int i = 0; i < 6; i++) begin
         nxt();
         wr_reg(0, i, rnd[15:0] & 16'h1F1F);
      end
      chk_regs();
      unlock(16'h0040);
      unlock(16'h0000);
      chk_regs();
      unlock(16'h0040);
      one_way_lock_config_bit = 1'b1;
      unlock(16'h0000);
      chk_regs();
      reset_n = 1'b0;
      @(negedge clk);
      reset_n = 1'b1;
      reset_shadow();
      chk_regs();
      unlock(16'h0040);
      unlock(16'h0000);
      wr_reg(0, 0, 16'h0101);
      chk_regs();
      chk_routes();
      end_sim();
   end
endmodule // prm_matrix_tb
